// file: common/bpc_defines.svh
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH
// system clock and link clock divider
`define BPC_SYS_NS     10
`define BPC_CK_DIV     8
`define BPC_CK_HALF    4
`define BPC_TCK_NS     (`BPC_SYS_NS * `BPC_CK_DIV)
// least times round up to whole link cycles
`define BPC_RU(ns)     (((ns) + `BPC_TCK_NS - 1) / `BPC_TCK_NS)
`define BPC_T_RCD_NS   18
`define BPC_T_RAS_NS   42
`define BPC_T_RPPB_NS  18
`define BPC_T_RPAB_NS  21
`define BPC_T_RC_NS    63
`define BPC_T_WR_NS    18
`define BPC_T_RTP_NS   8
`define BPC_N_RCD      `BPC_RU(`BPC_T_RCD_NS)
`define BPC_N_RAS      `BPC_RU(`BPC_T_RAS_NS)
`define BPC_N_RPPB     `BPC_RU(`BPC_T_RPPB_NS)
`define BPC_N_RPAB     (`BPC_RU(`BPC_T_RPAB_NS) + 1)
`define BPC_N_RC       `BPC_RU(`BPC_T_RC_NS)
`define BPC_N_WR       `BPC_RU(`BPC_T_WR_NS)
`define BPC_N_RTP      `BPC_RU(`BPC_T_RTP_NS)
// latency and burst figures in link cycles
`define BPC_WL         8'h08
`define BPC_HALF_BL16  8'h08
`define BPC_HALF_BL32  8'h10
`define BPC_BL32_EXTRA 8'h08
// command word fields
`define BPC_FLAG_POS   5
`define BPC_BANK_MSB   2
`define BPC_RST_CA     6'h00
`endif

// file: common/bpc_pkg.sv
package bpc_pkg;
  typedef enum logic [2:0] {
    BPC_NOP = 3'b000,
    BPC_ACT = 3'b001,
    BPC_RD  = 3'b010,
    BPC_WR  = 3'b011,
    BPC_MWR = 3'b100,
    BPC_PRE = 3'b101
  } bpc_cmd_t;
  typedef enum logic [1:0] {
    BPC_IDLE  = 2'b00,
    BPC_WORD1 = 2'b01,
    BPC_WORD2 = 2'b10
  } bpc_fsm_t;
  typedef struct packed {
    logic       open;
    logic       ap_pend;
    logic [7:0] pre;
    logic [7:0] act;
    logic [7:0] rcd;
    logic [7:0] ras;
    logic [7:0] rc;
    logic [7:0] ap;
    logic [7:0] rdap;
  } bpc_bank_t;
  typedef struct packed {
    bpc_fsm_t   fsm;
    logic [2:0] div;
    logic       ck;
    logic       cs;
    logic [5:0] ca;
    logic       ready;
    logic [2:0] bank;
  } bpc_top_t;
endpackage

// file: logic/bpc_bank_timer.sv
`timescale 1ns/10ps
`include "bpc_defines.svh"
module bpc_bank_timer import bpc_pkg::*; (
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  input  wire logic     tick,
  input  wire logic     cmd_valid,
  input  wire bpc_cmd_t cmd,
  input  wire logic     hit,
  input  wire logic     all_bank_flag,
  input  wire logic     auto_close_bit,
  input  wire logic     bl32,
  output logic          is_open,
  output logic          pre_ok,
  output logic          act_ok,
  output logic          rw_ok,
  output logic          rdap_ok
);
  bpc_bank_t s_q;
  bpc_bank_t s_d;
  logic [7:0] half;
  logic [7:0] rgap;
  logic [7:0] wgap;

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [7:0] dec8(input logic [7:0] a);
    return (a == 8'h00) ? 8'h00 : a - 8'h01;
  endfunction

  // burst-dependent gaps in link cycles
  assign half = bl32 ? `BPC_HALF_BL32 : `BPC_HALF_BL16;
  assign rgap = half - 8'h08 + 8'(`BPC_N_RTP);
  assign wgap = `BPC_WL + half + 8'h01 + 8'(`BPC_N_WR);

  // counters fall on link rising edges, commands land on falling edges
  always_comb begin
    s_d = s_q;
    if (tick) begin
      s_d.pre  = dec8(s_q.pre);
      s_d.act  = dec8(s_q.act);
      s_d.rcd  = dec8(s_q.rcd);
      s_d.ras  = dec8(s_q.ras);
      s_d.rc   = dec8(s_q.rc);
      s_d.ap   = dec8(s_q.ap);
      s_d.rdap = dec8(s_q.rdap);
      if (s_q.ap_pend && s_q.ap == 8'h00) begin
        s_d.open    = 1'b0;
        s_d.ap_pend = 1'b0;
        s_d.act     = max8(8'(`BPC_N_RPPB), s_d.rc);
      end
    end
    if (cmd_valid && hit) begin
      unique case (cmd)
        BPC_ACT: begin
          s_d.open = 1'b1;
          s_d.rcd  = 8'(`BPC_N_RCD);
          s_d.ras  = 8'(`BPC_N_RAS);
          s_d.rc   = 8'(`BPC_N_RC);
          s_d.pre  = 8'(`BPC_N_RAS);
        end
        BPC_RD: begin
          s_d.pre = max8(max8(s_q.pre, s_q.ras), max8(half, rgap));
          if (auto_close_bit) begin
            s_d.ap_pend = 1'b1;
            s_d.ap      = max8(s_q.ras, rgap);
          end
        end
        BPC_WR, BPC_MWR: begin
          s_d.pre  = max8(s_q.pre, wgap);
          // read with close must not cut recovery
          s_d.rdap = (wgap > rgap) ? wgap - rgap : 8'h00;
          if (auto_close_bit) begin
            s_d.ap_pend = 1'b1;
            s_d.ap      = max8(s_q.ras, wgap);
          end
        end
        BPC_PRE: begin
          if (s_q.open) begin
            s_d.open = 1'b0;
            s_d.act  = max8(all_bank_flag ? 8'(`BPC_N_RPAB) : 8'(`BPC_N_RPPB), s_q.rc);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign act_ok  = !s_q.open && s_q.act == 8'h00;
  assign pre_ok  = s_q.pre == 8'h00 && !s_q.ap_pend;
  assign rw_ok   = s_q.open && s_q.rcd == 8'h00 && !s_q.ap_pend;
  assign rdap_ok = s_q.rdap == 8'h00;
  assign is_open = s_q.open;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_pre_ras_met: assert property (cmd_valid && hit && cmd == BPC_PRE && s_q.open |-> s_q.ras == 8'h00)
    else $error("precharge before row active time");
  chk_act_rc_met: assert property (cmd_valid && hit && cmd == BPC_ACT |-> s_q.rc == 8'h00 && !s_q.open)
    else $error("activate before row cycle time");
  chk_noap_stays: assert property (cmd_valid && hit && cmd == BPC_RD && !auto_close_bit && s_q.open |=> s_q.open && !s_q.ap_pend)
    else $error("bank closed without auto close");
  chk_ap_closes: assert property (tick && s_q.ap_pend && s_q.ap == 8'h00 && !(cmd_valid && hit) |=> !s_q.open)
    else $error("auto close did not close bank");
  chk_act_load: assert property (cmd_valid && hit && cmd == BPC_ACT |=> s_q.ras == 8'(`BPC_N_RAS) && s_q.open)
    else $error("activate did not load row timers");
endmodule // bpc_bank_timer

// file: logic/bpc_host.sv
`timescale 1ns/10ps
`include "bpc_defines.svh"
// Contract
// - all-bank flag set ignores bank bits; else bank bits pick one of eight.
// - activate only after tRPab or tRPpb following the precharge.
// - precharge no earlier than BL/2 after read, and after tRAS.
// - wait tRP after precharge before activating that bank.
// - read-to-precharge counted from BL/2 - 8 after the read.
// - allow write recovery before precharge after a write burst.
// - write to precharge at least WL + BL/2 + 1 + write recovery.
// - activate after read auto-close needs tRP and tRC both.
// - activate after any auto-close needs tRC since last activate.
// - auto-close access allowed after tRCD; close deferred to honour tRAS.
// - write then read auto-close must not shorten write recovery.
module bpc_host import bpc_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       req_valid,
  input  wire bpc_cmd_t   req_cmd,
  input  wire logic [2:0] req_bank,
  input  wire logic       req_all,
  input  wire logic       req_auto_close,
  input  wire logic       bl32,
  output logic            req_ready,
  output logic            link_ck,
  output logic            link_cs,
  output logic [5:0]      command_address_bus,
  output logic [7:0]      bank_open
);
  // registered state and its next value
  bpc_top_t   s_q;
  bpc_top_t   s_d;
  logic       tick;
  logic       fall;
  logic       launch;
  logic       legal;
  // per-bank select sent to, and status gathered from, the eight timers
  logic [7:0] hit;
  logic [7:0] pre_ok;
  logic [7:0] act_ok;
  logic [7:0] rw_ok;
  logic [7:0] rdap_ok;

  // one-hot target, or every bank when the flag is set
  function automatic logic [7:0] bank_hit(input logic all, input logic [2:0] b);
    return all ? 8'hFF : 8'h01 << b;
  endfunction

  // link clock edges derived from the divider count
  assign tick = s_q.div == 3'(`BPC_CK_DIV - 1);
  assign fall = s_q.div == 3'(`BPC_CK_HALF - 1);

  assign hit = bank_hit(req_all && req_cmd == BPC_PRE, req_bank);

  // only a command that is legal for its bank now may start
  always_comb begin
    legal = 1'b0;
    unique case (req_cmd)
      BPC_ACT: legal = act_ok[req_bank];
      // reads after tRCD, auto close after recovery
      BPC_RD: legal = rw_ok[req_bank] && (!req_auto_close || rdap_ok[req_bank]);
      BPC_WR, BPC_MWR: legal = rw_ok[req_bank];
      BPC_PRE: legal = req_all ? &pre_ok : pre_ok[req_bank];
      default: legal = 1'b0;
    endcase
  end

  // a refused request just waits; nothing tells the requester why
  assign launch = s_q.fsm == BPC_IDLE && fall && req_valid && legal;

  // two-word command shifted out on falling edges so rising edges sample it
  always_comb begin
    s_d       = s_q;
    s_d.ready = 1'b0;
    s_d.div   = tick ? 3'h0 : s_q.div + 3'h1;
    s_d.ck    = (s_d.div >= 3'(`BPC_CK_HALF)) ? 1'b0 : 1'b1;
    unique case (s_q.fsm)
      BPC_IDLE: begin
        if (launch) begin
          s_d.fsm   = BPC_WORD1;
          s_d.cs    = 1'b1;
          s_d.ready = 1'b1;
          s_d.bank  = req_bank;
          s_d.ca    = {1'b0, 2'b00, req_cmd};
          // flag bit carries all-bank or auto-close
          s_d.ca[`BPC_FLAG_POS] = (req_cmd == BPC_PRE) ? req_all : req_auto_close;
        end
      end
      BPC_WORD1: begin
        if (fall) begin
          s_d.fsm = BPC_WORD2;
          s_d.cs  = 1'b0;
          s_d.ca  = {3'b000, s_q.bank};
        end
      end
      BPC_WORD2: begin
        if (fall) begin
          s_d.fsm = BPC_IDLE;
          s_d.ca  = `BPC_RST_CA;
        end
      end
      default: begin
        s_d.fsm = BPC_IDLE;
        s_d.cs  = 1'b0;
        s_d.ca  = `BPC_RST_CA;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.ck  <= 1'b1;
      s_q.fsm <= BPC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_bank
    bpc_bank_timer u_timer (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .tick           (tick),
      .cmd_valid      (launch),
      .cmd            (req_cmd),
      .hit            (hit[g]),
      .all_bank_flag  (req_all),
      .auto_close_bit (req_auto_close),
      .bl32           (bl32),
      .is_open        (bank_open[g]),
      .pre_ok         (pre_ok[g]),
      .act_ok         (act_ok[g]),
      .rw_ok          (rw_ok[g]),
      .rdap_ok        (rdap_ok[g])
    );
  end

  // outputs straight from the state register
  assign req_ready           = s_q.ready;
  assign link_ck             = s_q.ck;
  assign link_cs             = s_q.cs;
  assign command_address_bus = s_q.ca;

  // checks run on the system clock, off while in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_rp_order: assert property (`BPC_N_RPAB > `BPC_N_RPPB)
    else $error("all-bank precharge not longer");

  // select frames exactly one link cycle
  chk_cs_width: assert property ($rose(link_cs) |-> link_cs[*8] ##1 !link_cs)
    else $error("select not one link cycle wide");
  chk_cs_word1: assert property (link_cs |-> s_q.fsm == BPC_WORD1)
    else $error("select outside the first word");

  // link clock four high, four low, so each word is sampled mid-way
  chk_ck_high: assert property ($rose(link_ck) |-> link_ck[*4] ##1 !link_ck)
    else $error("link clock high phase wrong");
  chk_ck_low: assert property ($fell(link_ck) |-> !link_ck[*4] ##1 link_ck)
    else $error("link clock low phase wrong");

  // taken pulse lasts one cycle only
  chk_ready_pulse: assert property (req_ready |=> !req_ready)
    else $error("taken pulse longer than one cycle");

  // idle bus shows no select and a zero word
  chk_idle_quiet: assert property (s_q.fsm == BPC_IDLE |->
    !link_cs && command_address_bus == `BPC_RST_CA)
    else $error("bus not quiet while idle");

  // first word carries flag and code
  chk_flag_word: assert property (req_ready && $past(req_cmd) == BPC_PRE |->
    command_address_bus[`BPC_FLAG_POS] == $past(req_all))
    else $error("all-bank flag not on first word");
  chk_ap_word: assert property (req_ready && $past(req_cmd) != BPC_PRE |->
    command_address_bus[`BPC_FLAG_POS] == $past(req_auto_close))
    else $error("auto-close flag not on first word");
  chk_cmd_word: assert property (req_ready |->
    command_address_bus[2:0] == $past(req_cmd))
    else $error("command code not on first word");

  chk_bank_word: assert property ($fell(link_cs) |->
    command_address_bus[`BPC_BANK_MSB:0] == s_q.bank)
    else $error("bank bits wrong in second word");
  chk_word2_end: assert property ($fell(link_cs) |=>
    $stable(command_address_bus)[*7] ##1 command_address_bus == `BPC_RST_CA)
    else $error("second word not held for a link cycle");

  chk_ready_legal: assert property (req_ready |-> $past(legal) && $past(req_valid) && link_cs)
    else $error("command started while not legal");

  chk_act_closed: assert property (launch && req_cmd == BPC_ACT |->
    !bank_open[req_bank] ##1 bank_open[$past(req_bank)])
    else $error("activate on an open bank");
  chk_rw_open: assert property (launch && req_cmd inside {BPC_RD, BPC_WR, BPC_MWR} |->
    bank_open[req_bank])
    else $error("access to a closed bank");

  chk_pre_closes: assert property (launch && req_cmd == BPC_PRE && req_all |=>
    bank_open == 8'h00)
    else $error("all-bank precharge left a bank open");
  chk_pre_single: assert property (launch && req_cmd == BPC_PRE && !req_all |=>
    bank_open == ($past(bank_open) & ~bank_hit(1'b0, $past(req_bank))))
    else $error("single-bank precharge touched another bank");
endmodule // bpc_host

// file: bench/bpc_dev_model.sv
`timescale 1ns/10ps
// behavioural device: decodes the two command words and keeps the row state
module bpc_dev_model import bpc_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       link_ck,
  input  wire logic       link_cs,
  input  wire logic [5:0] command_address_bus,
  output logic [7:0]      dev_open,
  output logic [5:0]      word1,
  output logic [5:0]      word2
);
  logic       ck_q;
  logic       second_q;
  logic [2:0] b;
  assign b = command_address_bus[2:0];
  // sample on link rising edges; second word arrives with select already low
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_q <= 1'b1;
      second_q <= 1'b0;
      dev_open <= 8'h00;
      word1 <= 6'h00;
      word2 <= 6'h00;
    end else begin
      ck_q <= link_ck;
      if (link_ck && !ck_q && (link_cs || second_q)) begin
        second_q <= !second_q;
        if (!second_q) begin
          word1 <= command_address_bus;
        end else begin
          word2 <= command_address_bus;
          case (word1[2:0])
            3'h1: dev_open[b] <= 1'b1;
            3'h5: if (word1[5]) dev_open <= 8'h00; else dev_open[b] <= 1'b0;
            default: if (word1[5]) dev_open[b] <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule // bpc_dev_model

// file: bench/tb_top.sv
`timescale 1ns/10ps
`include "bpc_defines.svh"
module tb_top import bpc_pkg::*; ;
  localparam int N_RPPB = `BPC_N_RPPB;
  localparam int N_RPAB = `BPC_N_RPAB;
  localparam int N_RC   = `BPC_N_RC;
  localparam int N_WR   = `BPC_N_WR;
  localparam int N_RTP  = `BPC_N_RTP;
  localparam int W2P    = `BPC_WL + `BPC_HALF_BL16 + 1 + N_WR;
  logic       clk_sys, rst_n, req_valid, req_all, req_auto_close, bl32;
  logic       req_ready, link_ck, link_cs;
  bpc_cmd_t   req_cmd;
  logic [2:0] req_bank;
  logic [5:0] command_address_bus, word1, word2;
  logic [7:0] bank_open, dev_open;
  int         error_cnt = 0;
  int         n_checks = 0;

  bpc_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_all(req_all), .req_auto_close(req_auto_close), .bl32(bl32),
    .req_ready(req_ready), .link_ck(link_ck), .link_cs(link_cs),
    .command_address_bus(command_address_bus), .bank_open(bank_open));
  bpc_dev_model dev (.clk_sys(clk_sys), .rst_n(rst_n), .link_ck(link_ck), .link_cs(link_cs),
    .command_address_bus(command_address_bus), .dev_open(dev_open), .word1(word1),
    .word2(word2));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  // request held until taken; time stamp is the ready pulse
  task automatic issue(input bpc_cmd_t c, input logic [2:0] b, input logic a, input logic ac,
                       output longint t);
    int k;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_all <= a;
    req_auto_close <= ac;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
    end
    if (k == 3000) chk("req_ready", 0, 1);
    t = $time;
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask

  // auto close is internal; bound the wait for the row to drop
  task automatic wait_closed(input int b, output logic ok);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(negedge clk_sys);
      if (bank_open[b] === 1'b0) break;
    end
    ok = (k < 1000);
  endtask

  task automatic t_pre_sel();
    longint t;
    for (int b = 0; b < 8; b++) issue(BPC_ACT, 3'(b), 1'b0, 1'b0, t);
    repeat (17) @(posedge clk_sys);
    chk("open_all", bank_open, 8'hff);
    issue(BPC_PRE, 3'h5, 1'b0, 1'b0, t);
    repeat (17) @(posedge clk_sys);
    chk("pb_word1", word1, 6'h05);
    chk("pb_word2", word2, 6'h05);
    chk("pb_open", bank_open, 8'hdf);
    issue(BPC_PRE, 3'h2, 1'b1, 1'b0, t);
    repeat (17) @(posedge clk_sys);
    chk("ab_word1", word1, 6'h25);
    chk("ab_open", bank_open, 8'h00);
    chk("dev_open", dev_open, 8'h00);
    $display("done pre_sel");
  endtask

  task automatic t_rd_pre(input logic b32);
    longint t0, t1;
    bl32 <= b32;
    issue(BPC_ACT, 3'h0, 1'b0, 1'b0, t0);
    issue(BPC_RD, 3'h0, 1'b0, 1'b0, t0);
    repeat (17) @(posedge clk_sys);
    chk("rd_stays_open", bank_open[0], 1'b1);
    issue(BPC_PRE, 3'h0, 1'b0, 1'b0, t1);
    chk("rd_pre_gap", (t1 - t0) / 10 >= ((b32 ? 16 : 8) - 1) * 8, 1'b1);
    bl32 <= 1'b0;
    $display("done rd_pre");
  endtask

  task automatic t_wr_pre();
    longint t0, t1;
    logic ok;
    issue(BPC_ACT, 3'h1, 1'b0, 1'b0, t0);
    issue(BPC_WR, 3'h1, 1'b0, 1'b0, t0);
    issue(BPC_PRE, 3'h1, 1'b0, 1'b0, t1);
    chk("wr_pre_gap", (t1 - t0) / 10 >= (W2P - 1) * 8, 1'b1);
    // a read with close right behind a write must not cut recovery short
    issue(BPC_ACT, 3'h1, 1'b0, 1'b0, t0);
    issue(BPC_WR, 3'h1, 1'b0, 1'b0, t0);
    issue(BPC_RD, 3'h1, 1'b0, 1'b1, t1);
    wait_closed(1, ok);
    chk("wr_rdap_gap", (t1 - t0) / 10 >= (W2P - N_RTP - 1) * 8, 1'b1);
    chk("wr_rdap_closed", ok, 1'b1);
    $display("done wr_pre");
  endtask

  task automatic t_auto();
    longint t0, t1, tw, t;
    logic ok;
    issue(BPC_ACT, 3'h2, 1'b0, 1'b0, t0);
    issue(BPC_RD, 3'h2, 1'b0, 1'b1, t);
    wait_closed(2, ok);
    chk("rd_auto_closed", ok, 1'b1);
    // activate asked for at once after a write with close waits for that close
    issue(BPC_ACT, 3'h3, 1'b0, 1'b0, t);
    issue(BPC_WR, 3'h3, 1'b0, 1'b1, tw);
    issue(BPC_ACT, 3'h3, 1'b0, 1'b0, t);
    chk("wr_auto_act_gap", (t - tw) / 10 >= (W2P + N_RPPB - 1) * 8, 1'b1);
    issue(BPC_ACT, 3'h4, 1'b0, 1'b0, t);
    issue(BPC_MWR, 3'h4, 1'b0, 1'b1, t);
    wait_closed(4, ok);
    chk("mwr_auto_closed", ok, 1'b1);
    issue(BPC_ACT, 3'h2, 1'b0, 1'b0, t1);
    chk("act_act_gap", (t1 - t0) / 10 >= (N_RC - 1) * 8, 1'b1);
    $display("done auto");
  endtask

  task automatic t_rp();
    longint t0, t1, gpb, gab;
    issue(BPC_ACT, 3'h4, 1'b0, 1'b0, t0);
    issue(BPC_PRE, 3'h4, 1'b0, 1'b0, t0);
    issue(BPC_ACT, 3'h4, 1'b0, 1'b0, t1);
    gpb = (t1 - t0) / 10;
    issue(BPC_PRE, 3'h4, 1'b1, 1'b0, t0);
    issue(BPC_ACT, 3'h4, 1'b0, 1'b0, t1);
    gab = (t1 - t0) / 10;
    chk("pb_gap", gpb >= (N_RPPB - 1) * 8, 1'b1);
    chk("ab_gap", gab >= (N_RPAB - 1) * 8, 1'b1);
    chk("ab_vs_pb", gab >= gpb, 1'b1);
    $display("done rp");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard: 20,000 cycles, about fourteen times a clean run
  initial begin
    #200_000;
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = BPC_NOP;
    req_bank = 3'h0;
    req_all = 1'b0;
    req_auto_close = 1'b0;
    bl32 = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_pre_sel();
    t_rd_pre(1'b0);
    t_rd_pre(1'b1);
    t_wr_pre();
    t_auto();
    t_rp();
    close_out();
  end
endmodule // tb_top
